// ### hw/epiu_edge_cell.sv
`timescale 1ns/1ns
module epiu_edge_cell #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         arst_n,
   // pins
   input  wire logic [W-1:0] pins,
   input  wire logic [W-1:0] mask,
   // result
   output logic              changed
);
   import epiu_pkg::*;
   logic [W-1:0] prev_q;
   // pin value a cycle ago; pins are already synchronous
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prev_q <= '0;
      end else begin
         prev_q <= pins;
      end
   end
   // any enabled toggle
   always_comb begin
      changed = |((pins ^ prev_q) & mask);
   end
endmodule // epiu_edge_cell

// ### hw/epiu_pkg.sv
package epiu_pkg;
   // register word indices; the byte address on the bus is index * 4
   localparam logic [7:0] IDX_MCU_CONTROL   = 8'h35;
   localparam logic [7:0] IDX_PC_MASK_LOW   = 8'h12;
   localparam logic [7:0] IDX_PC_MASK_HIGH  = 8'h13;
   localparam logic [7:0] IDX_GEN_IRQ_MASK  = 8'h3B;
   localparam logic [7:0] IDX_GEN_IRQ_FLAGS = 8'h3A;
   localparam logic [7:0] IDX_CPU_STATUS    = 8'h3F;
   localparam logic [7:0] IDX_IRQ_ACK       = 8'h40;
   localparam int         ADDR_W            = 10;
   // field positions
   localparam int         BIT_EXT           = 6;
   localparam int         BIT_G1            = 5;
   localparam int         BIT_G0            = 4;
   localparam int         BIT_GIE           = 7;
   localparam logic [7:0] IRQ_REG_MASK      = 8'h70;
   localparam logic [3:0] HIGH_MASK_BITS    = 4'hF;
   // reset values
   localparam logic [7:0] RST_BYTE          = 8'h00;
   localparam logic [31:0] UNMAPPED_DATA    = 32'h0000_0000;
   // sense modes
   typedef enum logic [1:0] {
      EPIU_LOW  = 2'b00,
      EPIU_ANY  = 2'b01,
      EPIU_FALL = 2'b10,
      EPIU_RISE = 2'b11
   } epiu_sense_e;
   // vector numbers
   localparam logic [1:0] VEC_NONE          = 2'h0;
   localparam logic [1:0] VEC_EXT           = 2'h1;
   localparam logic [1:0] VEC_G0            = 2'h2;
   localparam logic [1:0] VEC_G1            = 2'h3;
endpackage

// ### hw/epiu_sense.sv
`timescale 1ns/1ns
module epiu_sense (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       arst_n,
   // pin and mode
   input  wire logic       pin,
   input  wire logic [1:0] mode,
   // results
   output logic            edge_hit,
   output logic            level_low
);
   import epiu_pkg::*;
   logic samp_q;
   // sampled before edge detection, so one clean clock period is enough
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         samp_q <= 1'b1;
      end else begin
         samp_q <= pin;
      end
   end
   // edge decode by mode; level path uses the raw pin
   always_comb begin
      level_low = ~pin;
      case (epiu_sense_e'(mode))
         EPIU_LOW:  edge_hit = 1'b0;
         EPIU_ANY:  edge_hit = pin ^ samp_q;
         EPIU_FALL: edge_hit = samp_q & ~pin;
         EPIU_RISE: edge_hit = ~samp_q & pin;
         default:   edge_hit = 1'b0;
      endcase
   end
endmodule // epiu_sense

// ### hw/epiu_top.sv
`timescale 1ns/1ns
module epiu_top (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        arst_n,
   // avalon-mm slave
   input  wire logic [9:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // pins, read back from the pad whatever its direction
   input  wire logic        ext_irq_pin,
   input  wire logic [11:0] pin_change_inputs,
   // cpu side
   input  wire logic        io_clk_run,
   input  wire logic        vector_taken,
   output logic             irq_req_q,
   output logic [1:0]       irq_vector_q,
   output logic             wake_q
);
   import epiu_pkg::*;

   logic [7:0] mcu_control_q;
   logic [7:0] pin_change_mask_low_q;
   logic [3:0] pin_change_mask_high_q;
   logic [2:0] gen_mask_q;   // ext, g1, g0
   logic       ext_pin_flag_q;
   logic       group1_change_flag_q;
   logic       group0_change_flag_q;
   logic       gie_q;
   logic       ack_q;
   logic [31:0] rdata_q;
   logic       edge_hit;
   logic       level_low;
   logic       pin_change_group0_request;
   logic       pin_change_group1_request;
   logic       level_active;
   logic       ext_take;
   logic       g0_take;
   logic       g1_take;
   logic       wr_go;
   logic       rd_go;
   logic [7:0] idx;
   logic [7:0] wbyte;
   logic [1:0] vec_d;

   // decode helper used by read and write paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
      return a == b;
   endfunction

   // edge logic runs from our clock; the gate stands in for a stopped io clock
   epiu_sense u_sense (
      .clk       (clk),
      .arst_n    (arst_n),
      .pin       (ext_irq_pin),
      .mode      (mcu_control_q[1:0]),
      .edge_hit  (edge_hit),
      .level_low (level_low)
   );

   epiu_edge_cell #(.W(8)) u_g0 (
      .clk     (clk),
      .arst_n  (arst_n),
      .pins    (pin_change_inputs[7:0]),
      .mask    (pin_change_mask_low_q),
      .changed (pin_change_group0_request)
   );

   epiu_edge_cell #(.W(4)) u_g1 (
      .clk     (clk),
      .arst_n  (arst_n),
      .pins    (pin_change_inputs[11:8]),
      .mask    (pin_change_mask_high_q),
      .changed (pin_change_group1_request)
   );

   // bus decode: at most one access every two cycles, answered one cycle after it is taken
   assign idx   = avs_address[9:2];
   assign wbyte = avs_writedata[7:0];
   assign wr_go = avs_write & avs_waitrequest & ~ack_q & avs_byteenable[0];
   assign rd_go = avs_read & ~ack_q;

   // waitrequest high until the access completes, so the master holds its request
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
      end
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= ~((avs_read | avs_write) & ~ack_q);
      end
   end

   // sense control byte
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mcu_control_q <= RST_BYTE;
      end else if (wr_go && hit(idx, IDX_MCU_CONTROL)) begin
         mcu_control_q <= wbyte;
      end
   end

   // pin masks; reset zero so no pin contributes until enabled
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_change_mask_low_q  <= RST_BYTE;
         pin_change_mask_high_q <= '0;
      end else if (wr_go) begin
         if (hit(idx, IDX_PC_MASK_LOW)) begin
            pin_change_mask_low_q <= wbyte;
         end
         if (hit(idx, IDX_PC_MASK_HIGH)) begin
            pin_change_mask_high_q <= wbyte[3:0] & HIGH_MASK_BITS;
         end
      end
   end

   // general mask and global enable (global stands in for the cpu i-flag)
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gen_mask_q <= '0;
         gie_q      <= 1'b0;
      end else if (wr_go) begin
         if (hit(idx, IDX_GEN_IRQ_MASK)) begin
            gen_mask_q <= {wbyte[BIT_EXT], wbyte[BIT_G1], wbyte[BIT_G0]};
         end
         if (hit(idx, IDX_CPU_STATUS)) begin
            gie_q <= wbyte[BIT_GIE];
         end
      end
   end

   // service decode with fixed priority
   assign level_active = (epiu_sense_e'(mcu_control_q[1:0]) == EPIU_LOW) & level_low;
   assign ext_take = gie_q & gen_mask_q[2] & (ext_pin_flag_q | level_active);
   assign g0_take  = gie_q & gen_mask_q[0] & group0_change_flag_q;
   assign g1_take  = gie_q & gen_mask_q[1] & group1_change_flag_q;
   always_comb begin
      if (ext_take) begin
         vec_d = VEC_EXT;
      end else if (g0_take) begin
         vec_d = VEC_G0;
      end else if (g1_take) begin
         vec_d = VEC_G1;
      end else begin
         vec_d = VEC_NONE;
      end
   end

   // ext flag: set wins over clear; held clear in level mode
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ext_pin_flag_q <= 1'b0;
      end else if (epiu_sense_e'(mcu_control_q[1:0]) == EPIU_LOW) begin
         ext_pin_flag_q <= 1'b0;
      end else if (edge_hit && io_clk_run) begin
         ext_pin_flag_q <= 1'b1;
      end else if ((vector_taken && irq_vector_q == VEC_EXT) ||
                   (wr_go && hit(idx, IDX_GEN_IRQ_FLAGS) && wbyte[BIT_EXT])) begin
         ext_pin_flag_q <= 1'b0;
      end
   end

   // group flags: set wins over handler entry or write-one clear
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         group0_change_flag_q <= 1'b0;
         group1_change_flag_q <= 1'b0;
      end else begin
         if (pin_change_group0_request) begin
            group0_change_flag_q <= 1'b1;
         end else if ((vector_taken && irq_vector_q == VEC_G0) ||
                      (wr_go && hit(idx, IDX_GEN_IRQ_FLAGS) && wbyte[BIT_G0])) begin
            group0_change_flag_q <= 1'b0;
         end
         if (pin_change_group1_request) begin
            group1_change_flag_q <= 1'b1;
         end else if ((vector_taken && irq_vector_q == VEC_G1) ||
                      (wr_go && hit(idx, IDX_GEN_IRQ_FLAGS) && wbyte[BIT_G1])) begin
            group1_change_flag_q <= 1'b0;
         end
      end
   end

   // request and vector to the cpu; level request drops at the first clock edge after the pin rises
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_req_q    <= 1'b0;
         irq_vector_q <= VEC_NONE;
      end else begin
         irq_req_q    <= (vec_d != VEC_NONE);
         irq_vector_q <= vec_d;
      end
   end

   // wake: raw level and masked pin differences, no edge clock needed
   // limitation: a real part would use an unclocked path; here it is registered
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= (gen_mask_q[2] & level_active)
                 | (gen_mask_q[0] & pin_change_group0_request)
                 | (gen_mask_q[1] & pin_change_group1_request);
      end
   end

   // read mux; reserved bits are zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= UNMAPPED_DATA;
      end else if (rd_go) begin
         if (hit(idx, IDX_MCU_CONTROL)) begin
            rdata_q <= {24'h000000, mcu_control_q};
         end else if (hit(idx, IDX_PC_MASK_LOW)) begin
            rdata_q <= {24'h000000, pin_change_mask_low_q};
         end else if (hit(idx, IDX_PC_MASK_HIGH)) begin
            rdata_q <= {28'h0000000, pin_change_mask_high_q};
         end else if (hit(idx, IDX_GEN_IRQ_MASK)) begin
            rdata_q <= {24'h000000, 1'b0, gen_mask_q[2], gen_mask_q[1], gen_mask_q[0], 4'h0} &
                       {24'h000000, IRQ_REG_MASK};
         end else if (hit(idx, IDX_GEN_IRQ_FLAGS)) begin
            rdata_q <= {24'h000000, 1'b0, ext_pin_flag_q, group1_change_flag_q,
                        group0_change_flag_q, 4'h0};
         end else if (hit(idx, IDX_CPU_STATUS)) begin
            rdata_q <= {24'h000000, gie_q, 7'h00};
         end else begin
            rdata_q <= UNMAPPED_DATA;
         end
      end
   end
   assign avs_readdata = rdata_q;

endmodule // epiu_top

// ### sim/epiu_chk.sv
`timescale 1ns/1ns
module epiu_chk
   import epiu_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        arst_n,
   // bus
   input wire logic [9:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // pins and cpu side
   input wire logic        ext_irq_pin,
   input wire logic [11:0] pin_change_inputs,
   input wire logic        vector_taken,
   input wire logic        irq_req_q,
   input wire logic [1:0]  irq_vector_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // activity that may legally raise a request
   logic [12:0] pins_q;
   logic [3:0]  act_q;
   wire         act = avs_write || ({ext_irq_pin, pin_change_inputs} != pins_q);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pins_q <= 13'h0000;
         act_q  <= 4'h0;
      end else begin
         pins_q <= {ext_irq_pin, pin_change_inputs};
         act_q  <= {act_q[2:0], act};
      end
   end
   sequence s_ack_rd;
      avs_read && !avs_waitrequest;
   endsequence
   sequence s_calm;
      (!act && !vector_taken)[*3];
   endsequence
   a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("no answer one cycle after request");
   a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_taken_clears: assert property (vector_taken && irq_vector_q == VEC_G1 && !act |=> ##1 irq_vector_q != VEC_G1)
      else $error("group1 vector still offered after handler entry");
   a_rise_cause: assert property ($rose(irq_req_q) |-> act || act_q != 4'h0)
      else $error("request rose without cause");
   a_req_hold: assert property (s_calm ##0 irq_req_q |=> irq_req_q)
      else $error("request dropped while quiet");
   a_unused_zero: assert property (s_ack_rd ##0 (avs_address[9:2] == IDX_GEN_IRQ_MASK
      || avs_address[9:2] == IDX_GEN_IRQ_FLAGS) |-> (avs_readdata & ~32'h70) == 32'h0)
      else $error("reserved bits read nonzero");
   a_high_bits: assert property (s_ack_rd ##0 avs_address[9:2] == IDX_PC_MASK_HIGH
      |-> avs_readdata[31:4] == 28'h0)
      else $error("high mask upper bits nonzero");
   a_unmapped_rd: assert property (s_ack_rd ##0 avs_address[9:2] == IDX_IRQ_ACK
      |-> avs_readdata == UNMAPPED_DATA)
      else $error("unmapped read nonzero");
endmodule // epiu_chk
bind epiu_top epiu_chk u_chk (.clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_readdata,
   .avs_waitrequest, .ext_irq_pin, .pin_change_inputs, .vector_taken, .irq_req_q, .irq_vector_q);

// ### sim/epiu_pins.sv
`timescale 1ns/1ns
module epiu_pins (
   // pad levels seen by the block
   output logic        ext_irq_pin,
   output logic [11:0] pin_change_inputs
);
   // pads idle high and low; own output drive reads back the same way
   initial begin
      ext_irq_pin = 1'b1;
      pin_change_inputs = 12'h000;
   end
   // flip chosen pads; a level stays until flipped again
   task automatic flip(input logic e, input logic [11:0] p);
      ext_irq_pin <= ext_irq_pin ^ e;
      pin_change_inputs <= pin_change_inputs ^ p;
   endtask
endmodule // epiu_pins

// ### sim/testbench.sv
`timescale 1ns/1ns
module testbench;
   import epiu_pkg::*;
   logic        clk, arst_n, avs_read, avs_write, avs_waitrequest;
   logic        io_clk_run, vector_taken, ext_irq_pin, irq_req_q, wake_q;
   logic [9:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0]  avs_byteenable;
   logic [11:0] pin_change_inputs;
   logic [1:0]  irq_vector_q;
   logic [31:0] exp_list[$];
   logic [7:0]  m, t;
   int          fails, compares, i;
   localparam logic [7:0] IDX_TAB [7] = '{IDX_MCU_CONTROL, IDX_PC_MASK_LOW, IDX_PC_MASK_HIGH,
      IDX_GEN_IRQ_MASK, IDX_GEN_IRQ_FLAGS, IDX_CPU_STATUS, IDX_IRQ_ACK};
   epiu_top uut (.clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
      .avs_readdata, .avs_waitrequest, .ext_irq_pin, .pin_change_inputs, .io_clk_run, .vector_taken,
      .irq_req_q, .irq_vector_q, .wake_q);
   epiu_pins pins (.ext_irq_pin, .pin_change_inputs);
   task automatic chk(input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one access, held until waitrequest is sampled low; an idle cycle follows
   task automatic acc(input logic w, input logic [7:0] idx, wd, ex);
      int n;
      n = 0;
      avs_address <= {idx, 2'b00};
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h000000, wd};
      if (!w) exp_list.push_back({24'h000000, ex});
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (avs_waitrequest !== 1'b0) begin
         fails++;
         give_verdict();
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] idx, wd);
      acc(1'b1, idx, wd, 8'h00);
   endtask
   task automatic rd(input logic [7:0] idx, ex);
      acc(1'b0, idx, 8'h00, ex);
   endtask
   // request reaches the outputs one edge after its flag
   task automatic irq(input logic r, input logic [1:0] v);
      repeat (3) @(posedge clk);
      chk({29'h0, irq_req_q, irq_vector_q}, {29'h0, r, v});
   endtask
   task automatic take;
      vector_taken <= 1'b1;
      @(posedge clk);
      vector_taken <= 1'b0;
      @(posedge clk);
   endtask
   // read data are judged at the edge where they stand
   always @(posedge clk)
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) chk(avs_readdata, exp_list.pop_front());
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      {arst_n, avs_read, avs_write, vector_taken} = 4'h0;
      {avs_address, avs_writedata} = 42'h0;
      avs_byteenable = 4'hF;
      io_clk_run = 1'b1;
      void'($urandom(27568));
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      for (i = 0; i < 7; i++) rd(IDX_TAB[i], 8'h00);
      // a write without the low byte lane must not land
      avs_byteenable <= 4'hE;
      wr(IDX_PC_MASK_LOW, 8'hFF);
      avs_byteenable <= 4'hF;
      rd(IDX_PC_MASK_LOW, 8'h00);
      wr(IDX_PC_MASK_HIGH, 8'hFF);
      rd(IDX_PC_MASK_HIGH, 8'h0F);
      wr(IDX_GEN_IRQ_MASK, 8'hFF);
      rd(IDX_GEN_IRQ_MASK, 8'h70);
      wr(IDX_IRQ_ACK, 8'hFF);
      // random masks and toggles on the low group, global enable off
      for (i = 0; i < 6; i++) begin
         m = 8'($urandom);
         t = 8'($urandom);
         wr(IDX_PC_MASK_LOW, m);
         pins.flip(1'b0, {4'h0, t});
         repeat (2) @(posedge clk);
         rd(IDX_GEN_IRQ_FLAGS, (|(m & t)) ? 8'h10 : 8'h00);
         irq(1'b0, VEC_NONE);
         wr(IDX_GEN_IRQ_FLAGS, 8'h10);
         rd(IDX_GEN_IRQ_FLAGS, 8'h00);
      end
      pins.flip(1'b0, 12'h400);
      irq(1'b0, VEC_NONE);
      rd(IDX_GEN_IRQ_FLAGS, 8'h20);
      wr(IDX_CPU_STATUS, 8'h80);
      irq(1'b1, VEC_G1);
      take();
      irq(1'b0, VEC_NONE);
      // edge modes: a fall then a rise, flag cleared by a written one
      for (i = 1; i < 4; i++) begin
         wr(IDX_MCU_CONTROL, 8'(i));
         pins.flip(1'b1, 12'h000);
         repeat (2) @(posedge clk);
         rd(IDX_GEN_IRQ_FLAGS, (i != 3) ? 8'h40 : 8'h00);
         wr(IDX_GEN_IRQ_FLAGS, 8'h40);
         pins.flip(1'b1, 12'h000);
         repeat (2) @(posedge clk);
         rd(IDX_GEN_IRQ_FLAGS, (i != 2) ? 8'h40 : 8'h00);
         wr(IDX_GEN_IRQ_FLAGS, 8'h40);
      end
      // three sources at once are served ext, group0, group1
      wr(IDX_MCU_CONTROL, 8'h02);
      wr(IDX_PC_MASK_LOW, 8'hFF);
      pins.flip(1'b1, 12'h101);
      irq(1'b1, VEC_EXT);
      take();
      irq(1'b1, VEC_G0);
      take();
      irq(1'b1, VEC_G1);
      take();
      irq(1'b0, VEC_NONE);
      pins.flip(1'b1, 12'h000);
      // let the rise settle before the next flip, or both land in one step
      @(posedge clk);
      // no io clock: a falling edge is not seen
      io_clk_run <= 1'b0;
      pins.flip(1'b1, 12'h000);
      irq(1'b0, VEC_NONE);
      io_clk_run <= 1'b1;
      pins.flip(1'b1, 12'h000);
      // low level mode requests while low, never sets the flag
      wr(IDX_MCU_CONTROL, 8'h00);
      pins.flip(1'b1, 12'h000);
      irq(1'b1, VEC_EXT);
      chk({31'h0, wake_q}, 32'h1);
      rd(IDX_GEN_IRQ_FLAGS, 8'h00);
      wr(IDX_CPU_STATUS, 8'h00);
      irq(1'b0, VEC_NONE);
      wr(IDX_CPU_STATUS, 8'h80);
      pins.flip(1'b1, 12'h000);
      irq(1'b0, VEC_NONE);
      give_verdict();
   end
endmodule // testbench
